// file: pkg/eic_pkg.sv
package eic_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned NS_PER_MS        = 1000000;
  localparam int unsigned MS_CYCLES        = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned EE_PROG_LOW_MS   = 2;   // Low supply (3 V) data store programming
  localparam int unsigned EE_PROG_HIGH_MS  = 1;   // High supply (5 V) data store programming
  localparam int unsigned IAP_PROG_MS      = 1;
  localparam int unsigned EE_READ_NS       = 300;
  localparam int unsigned EE_READ_CYCLES   = (EE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMO_SHORT_MS     = 1;
  localparam int unsigned TMO_MID_MS       = 4;
  localparam int unsigned TMO_LONG_MS      = 8;
  localparam int unsigned CNT_W            = 20;

  // Register offsets in the special function space
  localparam logic [7:0] SFR_UNLOCK_OFS    = 8'h97;
  localparam logic [7:0] SFR_WKEY_OFS      = 8'hc9;
  localparam logic [7:0] SFR_AUX_CONTROL_TWO_OFS      = 8'hd3;

  // Key values and reset values
  localparam logic [7:0] KEY_UNLOCK        = 8'h65;
  localparam logic [7:0] KEY_PROG_WRITE    = 8'h47;
  localparam logic [7:0] KEY_DATA_WRITE    = 8'he2;
  localparam logic [7:0] AUX_CONTROL_TWO_RESET        = 8'h03;

  // Field positions
  localparam int unsigned UNLOCK_FLAG_BIT  = 0;
  localparam int unsigned WKEY_PWE_BIT     = 7;
  localparam int unsigned WKEY_TMO_BIT     = 6;
  localparam int unsigned WKEY_EEWE_BIT    = 5;
  localparam int unsigned AUX_CONTROL_TWO_TSEL_LSB    = 0;

  // External data map
  localparam logic [15:0] EE_BASE          = 16'hee00;
  localparam logic [15:0] EE_END           = 16'heeff;
  localparam logic [15:0] EXTERNAL_DATA_RAM_BASE        = 16'hfc00;
  localparam logic [15:0] PROG_LAST_WR     = 16'h3ffe;
  localparam logic [15:0] PROG_LAST        = 16'h3fff;
  localparam int unsigned EE_BYTES         = 128;
  localparam int unsigned EXTERNAL_DATA_RAM_BYTES       = 1024;

  typedef enum logic [1:0]
  {
    TMO_OFF = 2'b00,
    TMO_1MS = 2'b01,
    TMO_4MS = 2'b10,
    TMO_8MS = 2'b11
  } eic_tmo_sel_t;

  typedef enum logic [2:0]
  {
    ST_IDLE       = 3'b000,
    ST_EE_READ    = 3'b001,
    ST_EE_PROG    = 3'b011,
    ST_IAP_PROG   = 3'b010,
    ST_IAP_SETTLE = 3'b110
  } eic_state_t;

  // External data access from the core
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eic_xreq_t;

  // Special function register access
  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eic_sfr_req_t;

endpackage : eic_pkg

// file: hdl/eic_ee_store.sv
`timescale 1ns/1ps

module eic_ee_store #(
  parameter int unsigned PROG_LOW_CYCLES  = eic_pkg::EE_PROG_LOW_MS * eic_pkg::MS_CYCLES,
  parameter int unsigned PROG_HIGH_CYCLES = eic_pkg::EE_PROG_HIGH_MS * eic_pkg::MS_CYCLES
)(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       supply_high_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            done_o
);

  if (PROG_LOW_CYCLES < 1 || PROG_HIGH_CYCLES < 1 ||
      PROG_LOW_CYCLES >= 2**eic_pkg::CNT_W || PROG_HIGH_CYCLES >= 2**eic_pkg::CNT_W)
  begin : g_bad_prog
    $error("eic_ee_store: programming time out of counter range");
  end

  logic [7:0]               mem [eic_pkg::EE_BYTES];
  logic                     busy_reg,  busy_next;
  logic [eic_pkg::CNT_W-1:0] cnt_reg,  cnt_next;
  logic [eic_pkg::CNT_W-1:0] lim_reg,  lim_next;
  logic [7:0]               data_reg,  data_next;
  logic                     done_next;
  logic                     commit;

  // Cell is written only when the full programming time has passed
  always_comb
  begin
    busy_next = busy_reg;
    cnt_next  = cnt_reg;
    lim_next  = lim_reg;
    data_next = data_reg;
    done_next = 1'b0;
    commit    = 1'b0;
    if (start_i)
    begin
      busy_next = 1'b1;
      cnt_next  = '0;
      data_next = wdata_i;
      lim_next  = supply_high_i ? eic_pkg::CNT_W'(PROG_HIGH_CYCLES - 1)
                                : eic_pkg::CNT_W'(PROG_LOW_CYCLES - 1);
    end
    else if (busy_reg && abort_i)
      busy_next = 1'b0;  // Escaped write leaves the cell untouched
    else if (busy_reg)
    begin
      if (cnt_reg == lim_reg)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
        commit    = 1'b1;
      end
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy_reg <= 1'b0;
      cnt_reg  <= '0;
      lim_reg  <= '0;
      data_reg <= 8'h00;
      done_o   <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
      cnt_reg  <= cnt_next;
      lim_reg  <= lim_next;
      data_reg <= data_next;
      done_o   <= done_next;
    end
  end

  // Storage array, no reset: contents survive like the real cells
  always_ff @(posedge clock_i)
  begin
    if (commit)
      mem[addr_i] <= data_reg;
    rdata_o <= mem[addr_i];
  end

endmodule : eic_ee_store

// file: hdl/eic_nvm_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - 128-byte data store with single-byte read and write.
// - Data store at even addresses EE00h..EEFEh only; odd ones invalid.
// - With data write flag set, window write programs byte with write data.
// - Core waits during data store programming, 2 ms low or 1 ms high supply.
// - Only the core is stalled; other peripherals keep running.
// - Interrupts raised during a stall stay pending; software services them after.
// - One timeout mechanism serves data store and program memory writes.
// - Window read returns the stored byte after about 300 ns.
// - Key 65h to unlock port sets access flag; any other value clears it.
// - Unlock port bit 0 reads back the program access flag.
// - 47h sets program write flag, E2h data write flag, others clear both.
// - Timeout flag bit 6 set on timeout, cleared when write flag clears.
// - Write key bit 5 reads the data write flag.
// - Write key bit 7 reads the program write flag.
// - Timeout select 00 off, else 1/4/8 ms; expiry flags and releases; reset 11.
// - Addresses FC00h..FFFFh decode to the 1024-byte external RAM.
// - Program memory write accepted only with program write flag set.
// - Accepted program memory write stalls the core about 1 ms.
// - Program memory reads add no wait states.

module eic_nvm_ctrl #(
  parameter int unsigned MS_CYCLES_P     = eic_pkg::MS_CYCLES,
  parameter int unsigned IAP_PROG_CYCLES = eic_pkg::IAP_PROG_MS * eic_pkg::MS_CYCLES,
  parameter int unsigned EE_LOW_CYCLES   = eic_pkg::EE_PROG_LOW_MS * eic_pkg::MS_CYCLES,
  parameter int unsigned EE_HIGH_CYCLES  = eic_pkg::EE_PROG_HIGH_MS * eic_pkg::MS_CYCLES
)(
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire eic_pkg::eic_sfr_req_t sfr_req_i,
  output logic [7:0]                sfr_rdata_o,
  input  wire eic_pkg::eic_xreq_t   xreq_i,
  output logic                      x_ack_o,
  output logic [7:0]                x_rdata_o,
  output logic                      cpu_wait_o,
  input  wire logic [7:0]           mtp_rdata_i,
  input  wire logic                 mtp_busy_i,
  output logic                      mtp_prog_o,
  output logic [13:0]               mtp_addr_o,
  output logic [7:0]                mtp_wdata_o,
  input  wire logic                 supply_high_i,
  output logic [7:0]                aux_control_two_o
);

  if (MS_CYCLES_P < 1 || MS_CYCLES_P >= 2**eic_pkg::CNT_W ||
      IAP_PROG_CYCLES < 1 || IAP_PROG_CYCLES >= 2**eic_pkg::CNT_W)
  begin : g_bad_time
    $error("eic_nvm_ctrl: time base out of counter range");
  end

  function automatic logic is_ee(input logic [15:0] a);
    is_ee = (a >= eic_pkg::EE_BASE) && (a <= eic_pkg::EE_END);
  endfunction : is_ee

  function automatic logic is_external_data_ram(input logic [15:0] a);
    is_external_data_ram = (a >= eic_pkg::EXTERNAL_DATA_RAM_BASE);
  endfunction : is_external_data_ram

  // Whole milliseconds until expiry for a timeout selection
  function automatic logic [3:0] tmo_limit(input logic [1:0] sel);
    case (sel)
      eic_pkg::TMO_1MS: tmo_limit = 4'(eic_pkg::TMO_SHORT_MS);
      eic_pkg::TMO_4MS: tmo_limit = 4'(eic_pkg::TMO_MID_MS);
      eic_pkg::TMO_8MS: tmo_limit = 4'(eic_pkg::TMO_LONG_MS);
      default:          tmo_limit = 4'h0;
    endcase
  endfunction : tmo_limit

  eic_pkg::eic_state_t       state_reg, state_next;
  logic [eic_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [eic_pkg::CNT_W-1:0] ms_div_reg, ms_div_next;
  logic [3:0]                ms_cnt_reg, ms_cnt_next;
  logic [6:0]                ee_addr_reg, ee_addr_next;
  logic [7:0]                x_rdata_next;
  logic                      x_ack_next;
  logic                      wait_next;
  logic                      mtp_prog_next;
  logic [13:0]               mtp_addr_next;
  logic [7:0]                mtp_wdata_next;
  logic                      ee_start;
  logic                      ee_abort;
  logic                      ee_done;
  logic [7:0]                ee_rdata;
  logic                      tmo_set;
  logic                      tmo_hit;
  logic                      external_data_ram_we;
  logic [7:0]                external_data_ram_rdata;
  logic [7:0]                external_data_ram_mem [eic_pkg::EXTERNAL_DATA_RAM_BYTES];
  logic                      sup_meta_reg, sup_sync_reg;
  logic                      access_reg, access_next;
  logic                      pwe_reg, pwe_next;
  logic                      eewe_reg, eewe_next;
  logic                      tmo_reg, tmo_next;
  logic [7:0]                aux_control_two_next;
  logic [7:0]                sfr_rdata_next;

  // Expiry compares a registered ms count, so it lands on a clean edge
  assign tmo_hit = (aux_control_two_o[eic_pkg::AUX_CONTROL_TWO_TSEL_LSB +: 2] != eic_pkg::TMO_OFF) &&
                   (ms_cnt_reg == tmo_limit(aux_control_two_o[eic_pkg::AUX_CONTROL_TWO_TSEL_LSB +: 2]));
  assign external_data_ram_rdata = external_data_ram_mem[xreq_i.addr[9:0]];

  // Access sequencer; the stall touches nothing but the core's wait line
  always_comb
  begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    ms_div_next    = ms_div_reg;
    ms_cnt_next    = ms_cnt_reg;
    ee_addr_next   = ee_addr_reg;
    x_rdata_next   = x_rdata_o;
    x_ack_next     = 1'b0;
    wait_next      = cpu_wait_o;
    mtp_prog_next  = mtp_prog_o;
    mtp_addr_next  = mtp_addr_o;
    mtp_wdata_next = mtp_wdata_o;
    ee_start       = 1'b0;
    ee_abort       = 1'b0;
    tmo_set        = 1'b0;
    external_data_ram_we        = 1'b0;
    // One shared millisecond base for both write kinds
    if (state_reg == eic_pkg::ST_EE_PROG || state_reg == eic_pkg::ST_IAP_PROG ||
        state_reg == eic_pkg::ST_IAP_SETTLE)
    begin
      if (ms_div_reg == eic_pkg::CNT_W'(MS_CYCLES_P - 1))
      begin
        ms_div_next = '0;
        if (ms_cnt_reg != 4'hf)
          ms_cnt_next = ms_cnt_reg + 1'b1;
      end
      else
        ms_div_next = ms_div_reg + 1'b1;
    end
    case (state_reg)
      eic_pkg::ST_IDLE:
      begin
        ms_div_next = '0;
        ms_cnt_next = 4'h0;
        cnt_next    = '0;
        if (xreq_i.wr)
        begin
          if (is_ee(xreq_i.addr) && eewe_reg && !xreq_i.addr[0])
          begin
            ee_start     = 1'b1;
            ee_addr_next = xreq_i.addr[7:1];
            wait_next    = 1'b1;
            state_next   = eic_pkg::ST_EE_PROG;
          end
          else if (is_external_data_ram(xreq_i.addr))
          begin
            external_data_ram_we    = 1'b1;
            x_ack_next = 1'b1;
          end
          else if (xreq_i.addr <= eic_pkg::PROG_LAST_WR && access_reg && pwe_reg)
          begin
            mtp_prog_next  = 1'b1;
            mtp_addr_next  = xreq_i.addr[13:0];
            mtp_wdata_next = xreq_i.wdata;
            wait_next      = 1'b1;
            state_next     = eic_pkg::ST_IAP_PROG;
          end
          else
            x_ack_next = 1'b1;
        end
        else if (xreq_i.rd)
        begin
          if (is_ee(xreq_i.addr) && !xreq_i.addr[0])
          begin
            ee_addr_next = xreq_i.addr[7:1];
            wait_next    = 1'b1;
            state_next   = eic_pkg::ST_EE_READ;
          end
          else
          begin
            x_ack_next = 1'b1;
            if (is_external_data_ram(xreq_i.addr))
              x_rdata_next = external_data_ram_rdata;
            else if (xreq_i.addr <= eic_pkg::PROG_LAST && access_reg)
              x_rdata_next = mtp_rdata_i;
            else
              x_rdata_next = 8'h00;
          end
        end
      end
      eic_pkg::ST_EE_READ:
      begin
        if (cnt_reg == eic_pkg::CNT_W'(eic_pkg::EE_READ_CYCLES - 1))
        begin
          x_ack_next   = 1'b1;
          x_rdata_next = ee_rdata;
          wait_next    = 1'b0;
          state_next   = eic_pkg::ST_IDLE;
        end
        else
          cnt_next = cnt_reg + 1'b1;
      end
      eic_pkg::ST_EE_PROG:
      begin
        if (ee_done)
        begin
          x_ack_next = 1'b1;
          wait_next  = 1'b0;
          state_next = eic_pkg::ST_IDLE;
        end
        else if (tmo_hit)
        begin
          ee_abort   = 1'b1;
          tmo_set    = 1'b1;
          x_ack_next = 1'b1;
          wait_next  = 1'b0;
          state_next = eic_pkg::ST_IDLE;
        end
      end
      eic_pkg::ST_IAP_PROG, eic_pkg::ST_IAP_SETTLE:
      begin
        if (tmo_hit)
        begin
          mtp_prog_next = 1'b0;
          tmo_set       = 1'b1;
          x_ack_next    = 1'b1;
          wait_next     = 1'b0;
          state_next    = eic_pkg::ST_IDLE;
        end
        else if (state_reg == eic_pkg::ST_IAP_PROG)
        begin
          if (cnt_reg == eic_pkg::CNT_W'(IAP_PROG_CYCLES - 1))
          begin
            mtp_prog_next = 1'b0;
            state_next    = eic_pkg::ST_IAP_SETTLE;
          end
          else
            cnt_next = cnt_reg + 1'b1;
        end
        else if (!mtp_busy_i)
        begin
          x_ack_next = 1'b1;
          wait_next  = 1'b0;
          state_next = eic_pkg::ST_IDLE;
        end
      end
      default:
      begin
        mtp_prog_next = 1'b0;
        wait_next     = 1'b0;
        state_next    = eic_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers; interrupt lines never pass through here
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg   <= eic_pkg::ST_IDLE;
      cnt_reg     <= '0;
      ms_div_reg  <= '0;
      ms_cnt_reg  <= 4'h0;
      ee_addr_reg <= 7'h00;
      x_rdata_o   <= 8'h00;
      x_ack_o     <= 1'b0;
      cpu_wait_o  <= 1'b0;
      mtp_prog_o  <= 1'b0;
      mtp_addr_o  <= 14'h0000;
      mtp_wdata_o <= 8'h00;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      ms_div_reg  <= ms_div_next;
      ms_cnt_reg  <= ms_cnt_next;
      ee_addr_reg <= ee_addr_next;
      x_rdata_o   <= x_rdata_next;
      x_ack_o     <= x_ack_next;
      cpu_wait_o  <= wait_next;
      mtp_prog_o  <= mtp_prog_next;
      mtp_addr_o  <= mtp_addr_next;
      mtp_wdata_o <= mtp_wdata_next;
    end
  end

  // Register file: key decoding, flags and read mux
  always_comb
  begin
    access_next    = access_reg;
    pwe_next       = pwe_reg;
    eewe_next      = eewe_reg;
    aux_control_two_next      = aux_control_two_o;
    sfr_rdata_next = 8'h00;
    if (sfr_req_i.wr)
    begin
      case (sfr_req_i.addr)
        eic_pkg::SFR_UNLOCK_OFS: access_next = (sfr_req_i.wdata == eic_pkg::KEY_UNLOCK);
        eic_pkg::SFR_WKEY_OFS:
        begin
          pwe_next  = (sfr_req_i.wdata == eic_pkg::KEY_PROG_WRITE);
          eewe_next = (sfr_req_i.wdata == eic_pkg::KEY_DATA_WRITE);
        end
        eic_pkg::SFR_AUX_CONTROL_TWO_OFS: aux_control_two_next = sfr_req_i.wdata;
        default: ;
      endcase
    end
    if (sfr_req_i.rd)
    begin
      case (sfr_req_i.addr)
        eic_pkg::SFR_UNLOCK_OFS: sfr_rdata_next[eic_pkg::UNLOCK_FLAG_BIT] = access_reg;
        eic_pkg::SFR_WKEY_OFS:
        begin
          sfr_rdata_next[eic_pkg::WKEY_PWE_BIT]  = pwe_reg;
          sfr_rdata_next[eic_pkg::WKEY_TMO_BIT]  = tmo_reg;
          sfr_rdata_next[eic_pkg::WKEY_EEWE_BIT] = eewe_reg;
        end
        eic_pkg::SFR_AUX_CONTROL_TWO_OFS: sfr_rdata_next = aux_control_two_o;
        default: sfr_rdata_next = 8'h00;
      endcase
    end
    // Set wins; clear fires on the falling write flags, not on their level
    if (tmo_set)
      tmo_next = 1'b1;
    else if ((pwe_reg || eewe_reg) && !(pwe_next || eewe_next))
      tmo_next = 1'b0;
    else
      tmo_next = tmo_reg;
  end

  // Flag registers, all write permissions closed after reset
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      access_reg        <= 1'b0;
      pwe_reg           <= 1'b0;
      eewe_reg          <= 1'b0;
      tmo_reg           <= 1'b0;
      aux_control_two_o <= eic_pkg::AUX_CONTROL_TWO_RESET;
      sfr_rdata_o       <= 8'h00;
    end
    else
    begin
      access_reg        <= access_next;
      pwe_reg           <= pwe_next;
      eewe_reg          <= eewe_next;
      tmo_reg           <= tmo_next;
      aux_control_two_o <= aux_control_two_next;
      sfr_rdata_o       <= sfr_rdata_next;
    end
  end

  // Supply level pin is asynchronous
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sup_meta_reg <= 1'b0;
      sup_sync_reg <= 1'b0;
    end
    else
    begin
      sup_meta_reg <= supply_high_i;
      sup_sync_reg <= sup_meta_reg;
    end
  end

  // External RAM, reachable only through this data path
  always_ff @(posedge clock_i)
  begin
    if (external_data_ram_we)
      external_data_ram_mem[xreq_i.addr[9:0]] <= xreq_i.wdata;
  end

  eic_ee_store #(
    .PROG_LOW_CYCLES  (EE_LOW_CYCLES),
    .PROG_HIGH_CYCLES (EE_HIGH_CYCLES)
  ) u_store (
    .clock_i       (clock_i),
    .resetn_i      (resetn_i),
    .start_i       (ee_start),
    .abort_i       (ee_abort),
    .supply_high_i (sup_sync_reg),
    .addr_i        (ee_start ? ee_addr_next : ee_addr_reg),
    .wdata_i       (xreq_i.wdata),
    .rdata_o       (ee_rdata),
    .done_o        (ee_done)
  );

endmodule : eic_nvm_ctrl

// file: testbench/eic_nvm_ctrl_properties.sv
`timescale 1ns/1ps
module eic_nvm_ctrl_chk #(
  parameter int unsigned IAP_PROG_CYCLES = eic_pkg::IAP_PROG_MS * eic_pkg::MS_CYCLES
)(
  input  wire logic                  clock_i,
  input  wire logic                  resetn_i,
  input  wire eic_pkg::eic_sfr_req_t sfr_req_i,
  input  wire logic [7:0]            sfr_rdata_o,
  input  wire eic_pkg::eic_xreq_t    xreq_i,
  input  wire logic                  x_ack_o,
  input  wire logic                  cpu_wait_o,
  input  wire logic                  mtp_prog_o,
  input  wire logic [13:0]           mtp_addr_o,
  input  wire logic [7:0]            mtp_wdata_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic        idle;
  int unsigned pcnt_reg;
  // No access in flight
  assign idle = !cpu_wait_o && !x_ack_o;
  // Length of the current programming pulse
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pcnt_reg <= 0;
    else
      pcnt_reg <= mtp_prog_o ? pcnt_reg + 1 : 0;
  end
  AST_EXTERNAL_DATA_RAM_FAST: assert property ((xreq_i.rd || xreq_i.wr) && xreq_i.addr >= 16'hfc00 && idle |->
    !cpu_wait_o ##1 !cpu_wait_o ##[0:1] x_ack_o) else $error("external_data_ram access stalled");
  AST_PROG_READ: assert property (xreq_i.rd && xreq_i.addr <= 16'h3fff && idle |=> !cpu_wait_o[*2])
    else $error("program read stalled");
  AST_EE_READ: assert property (xreq_i.rd && xreq_i.addr[15:8] == 8'hee && !xreq_i.addr[0] && idle
    |=> cpu_wait_o ##[27:31] x_ack_o) else $error("data store read timing");
  AST_ACK_WAIT: assert property (x_ack_o |-> !cpu_wait_o ##1 !x_ack_o) else $error("ack with wait");
  AST_STALL_CAUSE: assert property ($rose(cpu_wait_o) |-> $past(xreq_i.rd || xreq_i.wr))
    else $error("stall without request");
  AST_PROG_STALL: assert property (mtp_prog_o |-> cpu_wait_o) else $error("programming without stall");
  AST_PROG_STABLE: assert property (mtp_prog_o && $past(mtp_prog_o) |-> $stable(mtp_addr_o)
    && $stable(mtp_wdata_o)) else $error("program address moved");
  AST_PROG_LEN: assert property ($fell(mtp_prog_o) |-> pcnt_reg == IAP_PROG_CYCLES)
    else $error("programming pulse length");
  AST_SFR_IDLE: assert property (!$past(sfr_req_i.rd) |-> sfr_rdata_o == 8'h00)
    else $error("register data without read");
  cover property ($fell(mtp_prog_o));
  cover property (x_ack_o && $past(cpu_wait_o));
  cover property ($rose(cpu_wait_o) && $past(xreq_i.wr));
endmodule : eic_nvm_ctrl_chk

bind eic_nvm_ctrl eic_nvm_ctrl_chk #(.IAP_PROG_CYCLES(IAP_PROG_CYCLES)) u_eic_nvm_ctrl_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
  .xreq_i(xreq_i), .x_ack_o(x_ack_o), .cpu_wait_o(cpu_wait_o), .mtp_prog_o(mtp_prog_o),
  .mtp_addr_o(mtp_addr_o), .mtp_wdata_o(mtp_wdata_o));

// file: testbench/eic_mtp_model.sv
`timescale 1ns/1ps
module eic_mtp_model (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        prog_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [15:0] rd_addr_i,
  input  wire logic        slow_i,
  output logic      [7:0]  rdata_o,
  output logic             busy_o
);
  logic [7:0] mem [16384];
  int         hold_reg;
  // Cell takes the byte while programming; slow cells stay busy long
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hold_reg <= 0;
    else if (prog_i)
    begin
      mem[addr_i] <= wdata_i;
      hold_reg    <= slow_i ? 200 : 2;
    end
    else if (hold_reg != 0)
      hold_reg <= hold_reg - 1;
  end
  // Read data in the same cycle, no wait
  assign rdata_o = mem[rd_addr_i[13:0]];
  assign busy_o  = prog_i || hold_reg != 0;
endmodule : eic_mtp_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                  clock_i;
  logic                  resetn_i;
  logic                  supply;
  logic                  slow;
  eic_pkg::eic_sfr_req_t sfr_req;
  eic_pkg::eic_xreq_t    xreq;
  logic [7:0]            sfr_rdata, x_rdata, m_rdata, m_wdata, aux, xr_data;
  logic                  x_ack, cpu_wait, m_busy, m_prog, xr_wait;
  logic [13:0]           m_addr;
  int                    err_count, num_checks, xr_cnt;
  int                    cycles = 0;

  eic_nvm_ctrl #(.MS_CYCLES_P(20), .IAP_PROG_CYCLES(30), .EE_LOW_CYCLES(40), .EE_HIGH_CYCLES(20)) u_eic_nvm_ctrl (
    .clock_i(clock_i), .resetn_i(resetn_i), .sfr_req_i(sfr_req), .sfr_rdata_o(sfr_rdata),
    .xreq_i(xreq), .x_ack_o(x_ack), .x_rdata_o(x_rdata), .cpu_wait_o(cpu_wait),
    .mtp_rdata_i(m_rdata), .mtp_busy_i(m_busy), .mtp_prog_o(m_prog), .mtp_addr_o(m_addr),
    .mtp_wdata_o(m_wdata), .supply_high_i(supply), .aux_control_two_o(aux));
  eic_mtp_model u_eic_mtp_model (
    .clock_i(clock_i), .resetn_i(resetn_i), .prog_i(m_prog), .addr_i(m_addr), .wdata_i(m_wdata),
    .rd_addr_i(xreq.addr), .slow_i(slow), .rdata_o(m_rdata), .busy_o(m_busy));

  // 100 MHz clock
  initial
  begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Hang guard, far above the expected run
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("ERROR %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_cnt(input int lo, input int hi);
    num_checks++;
    if (xr_cnt < lo || xr_cnt > hi)
    begin
      err_count++;
      $display("ERROR %0t: %0d cycles expected %0d to %0d", $time, xr_cnt, lo, hi);
    end
  endtask : chk_cnt

  // An idle edge first, so no strobe is driven twice in one step
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1 sfr_req = '{1'b0, 1'b1, a, d};
    @(posedge clock_i);
    #1 sfr_req.wr = 1'b0;
  endtask : sfr_wr

  // Data stands one cycle after the read strobe
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    #1 sfr_req = '{1'b1, 1'b0, a, 8'h00};
    @(posedge clock_i);
    #1 sfr_req.rd = 1'b0;
    chk8(sfr_rdata, e);
  endtask : sfr_rd

  // One-cycle request, then count cycles up to the ack
  task automatic xacc(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1 xreq = '{rd, !rd, a, d};
    xr_cnt  = 0;
    xr_wait = 1'b0;
    @(posedge clock_i);
    #1 xreq.rd = 1'b0;
    xreq.wr = 1'b0;
    while (x_ack !== 1'b1 && xr_cnt < 2000)
    begin
      xr_wait = xr_wait | cpu_wait;
      @(posedge clock_i);
      #1 xr_cnt++;
    end
    xr_data = x_rdata;
  endtask : xacc

  task automatic t_regs();
    sfr_rd(8'h97, 8'h00);
    sfr_rd(8'hc9, 8'h00);
    sfr_rd(8'hd3, 8'h03);
    chk8(aux, 8'h03);
    sfr_rd(8'h80, 8'h00);
    sfr_wr(8'h97, 8'h65);
    sfr_rd(8'h97, 8'h01);
    sfr_wr(8'h97, 8'h56);
    sfr_rd(8'h97, 8'h00);
    sfr_wr(8'hc9, 8'h47);
    sfr_rd(8'hc9, 8'h80);
    sfr_wr(8'hc9, 8'he2);
    sfr_rd(8'hc9, 8'h20);
    sfr_wr(8'hc9, 8'h3c);
    sfr_rd(8'hc9, 8'h00);
    sfr_wr(8'hd3, 8'ha4);
    sfr_rd(8'hd3, 8'ha4);
    chk8(aux, 8'ha4);
  endtask : t_regs

  task automatic t_external_data_ram();
    xacc(1'b0, 16'hfc10, 8'h5a);
    chk_cnt(0, 1);
    xacc(1'b0, 16'hffff, 8'hc3);
    xacc(1'b1, 16'hfc10, 8'h00);
    chk8(xr_data, 8'h5a);
    xacc(1'b1, 16'hffff, 8'h00);
    chk8(xr_data, 8'hc3);
  endtask : t_external_data_ram

  task automatic t_ee();
    xacc(1'b0, 16'hee04, 8'h11);
    chk_cnt(0, 1);
    sfr_wr(8'hc9, 8'he2);
    xacc(1'b0, 16'hee05, 8'h22);
    chk8({7'h00, xr_wait}, 8'h00);
    xacc(1'b0, 16'hee04, 8'ha5);
    chk_cnt(19, 24);
    xacc(1'b1, 16'hee04, 8'h00);
    chk8(xr_data, 8'ha5);
    chk_cnt(28, 30);
    // Low supply doubles the write time
    supply = 1'b0;
    repeat (3) @(posedge clock_i); // Gap between writes
    #1 xacc(1'b0, 16'hee7e, 8'h3c);
    chk_cnt(39, 44);
    xacc(1'b1, 16'hee7e, 8'h00);
    chk8(xr_data, 8'h3c);
    xacc(1'b1, 16'hee04, 8'h00);
    chk8(xr_data, 8'ha5);
  endtask : t_ee

  task automatic t_tmo();
    sfr_wr(8'hd3, 8'h01);
    xacc(1'b0, 16'hee04, 8'h77);
    chk_cnt(18, 23);
    sfr_rd(8'hc9, 8'h60);
    xacc(1'b1, 16'hee04, 8'h00);
    chk8(xr_data, 8'ha5);
    sfr_wr(8'hc9, 8'h00);
    sfr_rd(8'hc9, 8'h00);
  endtask : t_tmo

  task automatic t_iap();
    sfr_wr(8'hd3, 8'h00);
    sfr_wr(8'h97, 8'h65);
    sfr_wr(8'hc9, 8'h47);
    xacc(1'b0, 16'h3000, 8'h5a);
    chk_cnt(30, 38);
    xacc(1'b1, 16'h3000, 8'h00);
    chk8(xr_data, 8'h5a);
    chk8({7'h00, xr_wait}, 8'h00);
    sfr_wr(8'hc9, 8'h00);
    xacc(1'b0, 16'h3000, 8'h11);
    chk_cnt(0, 1);
    xacc(1'b1, 16'h3000, 8'h00);
    chk8(xr_data, 8'h5a);
    // Stuck program cell escapes by the shared timeout
    slow = 1'b1;
    sfr_wr(8'hd3, 8'h02);
    sfr_wr(8'hc9, 8'h47);
    xacc(1'b0, 16'h3002, 8'h22);
    chk_cnt(78, 83);
    sfr_rd(8'hc9, 8'hc0);
    sfr_wr(8'hc9, 8'h00);
    sfr_rd(8'hc9, 8'h00);
    sfr_wr(8'h97, 8'h00);
    xacc(1'b1, 16'h3000, 8'h00);
    chk8(xr_data, 8'h00);
  endtask : t_iap

  // Mid-run reset, then the 8 ms escape from a stuck program cell
  task automatic t_rst();
    sfr_wr(8'h97, 8'h65);
    sfr_wr(8'hc9, 8'h47);
    resetn_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    sfr_rd(8'h97, 8'h00);
    sfr_rd(8'hc9, 8'h00);
    sfr_rd(8'hd3, 8'h03);
    sfr_wr(8'h97, 8'h65);
    sfr_wr(8'hc9, 8'h47);
    xacc(1'b0, 16'h3004, 8'h33);
    chk_cnt(158, 163);
    sfr_rd(8'hc9, 8'hc0);
  endtask : t_rst

  initial
  begin
    resetn_i   = 1'b0;  // No watchdog or voltage guard to set here
    supply     = 1'b1;
    slow       = 1'b0;
    sfr_req    = '0;
    xreq       = '0;
    err_count  = 0;
    num_checks = 0;
    repeat (16) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    t_regs();
    t_external_data_ram();
    t_ee();
    t_tmo();
    t_iap();
    t_rst();
    final_report();
  end
endmodule : tb_top
